// >>> rtl/plp_device.sv
// Purpose: serially programmed divider, phase detector, lock and switch logic
// Assumes: system clock acts as reference oscillator; vco_in is a slow pulse train
// Notes: analog parts reduced to drive level plus output enable
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - host keeps prescaler select zero
// - fourteen reference bits load reference counter
// - host sets control bit in reference words
// - host shifts words most significant first
// - 19-bit shift, 18-bit latch, swallow, main counters
// - low seven bits set swallow count
// - upper eleven bits set main count
// - host clears control bit in main words
// - one bit captured per serial clock rise
// - strobe raised after last clock rise
// - power save high means normal operation
// - power save low: stand-by, lock shows locked
// - stand-by leaves pump output high impedance
// - leaving stand-by realigns both divided phases
// - host holds stand-by during power up
// - polarity input sets pump drive sense
// - lock after three cycles within window
// - strobe high routes pump to switch pin
// - strobe rise copies word by control bit
// - host never programs reference below eight
module plp_device
    import plp_pkg::*;
#(
    parameter logic [REF_W-1:0] REF_INIT = REF_MIN,
    parameter logic [MAIN_W-1:0] MAIN_INIT = MAIN_MIN
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // programming link
    plp_link_if.dev link,
    // vco pulses into the internal 128/129 prescaler
    input wire logic vco_in,
    // charge pump and analog switch
    output logic pump_out,
    output logic pump_oe_n,
    output logic switch_out,
    output logic switch_oe_n,
    // monitors
    output logic divided_reference,
    output logic divided_vco,
    output logic standby
);
    typedef struct packed {
        logic [NSYNC-1:0][2:0] sy;
        logic [NSYNC-1:0] st;
        logic [SR_W-1:0] sr;
        logic [REF_W:0] ref_lat;
        logic [MAIN_W+SWAL_W-1:0] main_lat;
        plp_mode_t mode;
        logic [REF_W-1:0] ref_cnt;
        logic [PRE_W-1:0] pre;
        logic [SWAL_W-1:0] swal_cnt;
        logic [MAIN_W-1:0] main_cnt;
        logic fref;
        logic fvco;
        logic up;
        logic dn;
        logic [6:0] wid;
        logic [1:0] good;
        logic locked;
        logic lock;
        logic pump;
        logic pump_oe_n;
        logic sw;
        logic sw_oe_n;
    } plp_dev_state_t;

    localparam plp_dev_state_t DEV_RESET = '{
        ref_lat: {REF_INIT, 1'b0},
        main_lat: {MAIN_INIT, SWAL_INIT},
        mode: MODE_STANDBY,
        ref_cnt: REF_INIT,
        main_cnt: MAIN_INIT,
        lock: 1'b1,
        pump_oe_n: 1'b1,
        sw_oe_n: 1'b1,
        default: '0
    };

    plp_dev_state_t r;
    plp_dev_state_t n;
    logic [NSYNC-1:0] pin;
    logic [NSYNC-1:0] rise;
    logic [PRE_W-1:0] pre_last;
    logic active;

    assign pin = {vco_in, link.phase_polarity_input, link.power_save_input,
                  link.load_strobe, link.sdata, link.sclk};

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = r;
        rise = '0;
        pre_last = PRE_LOW_LAST;
        active = 1'b0;
        n.fref = 1'b0;
        n.fvco = 1'b0;
        for (int i = 0; i < NSYNC; i++) begin
            n.sy[i] = {r.sy[i][1:0], pin[i]};
            n.st[i] = plp_settle(r.sy[i], r.st[i]);
            rise[i] = n.st[i] & ~r.st[i];
        end
        // serial loading
        if (rise[IX_SCLK]) begin
            n.sr = {r.sr[SR_W-2:0], r.st[IX_DATA]};
        end
        if (rise[IX_LE]) begin
            if (r.sr[CTRL_BIT]) begin
                n.ref_lat = r.sr[REF_LSB+REF_W-1:SWSEL_BIT];
            end else begin
                n.main_lat = r.sr[SR_W-1:SWAL_LSB];
            end
        end
        n.mode = n.st[IX_PS] ? MODE_RUN : MODE_STANDBY;
        if (n.mode == MODE_RUN && r.mode == MODE_STANDBY) begin
            // restart both dividers together so the first comparison is aligned
            n.ref_cnt = r.ref_lat[REF_W:1];
            n.main_cnt = r.main_lat[MAIN_W+SWAL_W-1:SWAL_W];
            n.swal_cnt = r.main_lat[SWAL_W-1:0];
            n.pre = '0;
            n.up = 1'b0;
            n.dn = 1'b0;
            n.wid = '0;
        end else if (r.mode == MODE_RUN) begin
            // reference divider: reload only at terminal count
            if (r.ref_cnt <= 14'h0001) begin
                n.ref_cnt = r.ref_lat[REF_W:1];
                n.fref = 1'b1;
            end else begin
                n.ref_cnt = r.ref_cnt - 14'h0001;
            end
            // pulse swallow: 129 while swallow count remains, then 128
            pre_last = (r.swal_cnt != '0) ? PRE_HIGH_LAST : PRE_LOW_LAST;
            if (rise[IX_VCO]) begin
                if (r.pre >= pre_last) begin
                    n.pre = '0;
                    if (r.swal_cnt != '0) begin
                        n.swal_cnt = r.swal_cnt - 7'h01;
                    end
                    if (r.main_cnt <= 11'h001) begin
                        n.main_cnt = r.main_lat[MAIN_W+SWAL_W-1:SWAL_W];
                        n.swal_cnt = r.main_lat[SWAL_W-1:0];
                        n.fvco = 1'b1;
                    end else begin
                        n.main_cnt = r.main_cnt - 11'h001;
                    end
                end else begin
                    n.pre = r.pre + 8'h01;
                end
            end
            // phase detector and lock window
            n.up = r.up | r.fref;
            n.dn = r.dn | r.fvco;
            if (n.up ^ n.dn) begin
                if (r.wid < LOCK_CYC) begin
                    n.wid = r.wid + 7'h01;
                end
                if (n.wid >= LOCK_CYC) begin
                    n.locked = 1'b0;
                    n.good = '0;
                end
            end
            if (n.up & n.dn) begin
                n.up = 1'b0;
                n.dn = 1'b0;
                n.wid = '0;
                if (r.wid < LOCK_CYC) begin
                    if (r.good < LOCK_GOOD) begin
                        n.good = r.good + 2'h1;
                    end
                    if (r.good >= LOCK_GOOD - 2'h1) begin
                        n.locked = 1'b1;
                    end
                end
            end
        end
        // stand-by shows the locked level on the indicator
        n.lock = (n.mode == MODE_STANDBY) ? 1'b1 : n.locked;
        active = (n.mode == MODE_RUN) && (n.up ^ n.dn);
        n.pump = n.up ? n.st[IX_POL] : ~n.st[IX_POL];
        n.pump_oe_n = ~active;
        n.sw = n.pump;
        n.sw_oe_n = ~(n.st[IX_LE] & active);
    end

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r <= DEV_RESET;
        end else begin
            r <= n;
        end
    end

    assign link.lock_indicator = r.lock;
    assign pump_out = r.pump;
    assign pump_oe_n = r.pump_oe_n;
    assign switch_out = r.sw;
    assign switch_oe_n = r.sw_oe_n;
    assign divided_reference = r.fref;
    assign divided_vco = r.fvco;
    assign standby = (r.mode == MODE_STANDBY);
endmodule : plp_device

// >>> rtl/plp_pkg.sv
// Purpose: shared constants, types and helpers for the serial divider link
// Assumes: 50 MHz system clock on both ends
// Notes: word layout is control bit last, most significant bit first
package plp_pkg;
    localparam int SR_W = 19;
    localparam int REF_W = 14;
    localparam int SWAL_W = 7;
    localparam int MAIN_W = 11;
    localparam int PRE_W = 8;
    localparam int CTRL_BIT = 0;
    localparam int SWSEL_BIT = 1;
    localparam int REF_LSB = 2;
    localparam int SWAL_LSB = 1;
    localparam int MAIN_LSB = 8;
    localparam logic [4:0] REF_WORD_LEN = 5'h10;
    localparam logic [4:0] MAIN_WORD_LEN = 5'h13;
    // prescaler terminal counts for divide by 128 and by 129
    localparam logic [PRE_W-1:0] PRE_LOW_LAST = 8'h7f;
    localparam logic [PRE_W-1:0] PRE_HIGH_LAST = 8'h80;
    localparam logic [REF_W-1:0] REF_MIN = 14'h0008;
    localparam logic [MAIN_W-1:0] MAIN_MIN = 11'h010;
    localparam logic [SWAL_W-1:0] SWAL_INIT = 7'h00;
    localparam int CLK_PERIOD_NS = 20;
    localparam int LOCK_WINDOW_NS = 625;
    localparam logic [6:0] LOCK_CYC = 7'((LOCK_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [1:0] LOCK_GOOD = 2'h3;
    localparam int T_MIN_NS = 1000;
    localparam logic [6:0] T_MIN_CYC = 7'((T_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // synchroniser slots of the device
    localparam int NSYNC = 6;
    localparam int IX_SCLK = 0;
    localparam int IX_DATA = 1;
    localparam int IX_LE = 2;
    localparam int IX_PS = 3;
    localparam int IX_POL = 4;
    localparam int IX_VCO = 5;
    // host command port map
    localparam logic [3:0] ADDR_REF = 4'h0;
    localparam logic [3:0] ADDR_MAIN = 4'h1;
    localparam logic [3:0] ADDR_CTRL = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam int ST_BUSY = 0;
    localparam int ST_LOCK = 1;
    localparam int ST_REFUSED = 2;
    localparam int CT_PS = 0;
    localparam int CT_POL = 1;

    typedef enum logic {MODE_STANDBY = 1'b0, MODE_RUN = 1'b1} plp_mode_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000, H_SETUP = 3'b001, H_HIGH = 3'b010, H_STROBE = 3'b011, H_TAIL = 3'b100
    } plp_hstate_t;

    // settled value: follows the input once second and third stages agree
    function automatic logic plp_settle(input logic [2:0] s, input logic st);
        plp_settle = (s[1] == s[2]) ? s[2] : st;
    endfunction : plp_settle
endpackage : plp_pkg

// >>> rtl/plp_link_if.sv
// Purpose: three-wire programming link plus mode pins between host and device
// Assumes: host drives all but the lock indicator
// Notes: no clocking block; both ends sample with their own clock
`timescale 1ns/1ps
interface plp_link_if;
    logic sclk;
    logic sdata;
    logic load_strobe;
    logic power_save_input;
    logic phase_polarity_input;
    logic lock_indicator;
    modport host (output sclk, output sdata, output load_strobe, output power_save_input,
                  output phase_polarity_input, input lock_indicator);
    modport dev (input sclk, input sdata, input load_strobe, input power_save_input,
                 input phase_polarity_input, output lock_indicator);
endinterface : plp_link_if

// >>> rtl/plp_host.sv
// Purpose: host end that bit-bangs divider words and drives mode pins
// Assumes: command port with one-cycle strobes, read data one cycle later
// Notes: every link phase lasts at least one microsecond
`timescale 1ns/1ps
module plp_host
    import plp_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // programming link
    plp_link_if.host link,
    // command port
    input wire logic [3:0] cmd_addr,
    input wire logic [31:0] cmd_wdata,
    input wire logic cmd_write,
    input wire logic cmd_read,
    output logic [31:0] cmd_rdata
);
    typedef struct packed {
        logic [2:0] sy;
        logic st;
        plp_hstate_t state;
        logic [6:0] cnt;
        logic [4:0] bitn;
        logic [SR_W-1:0] word;
        logic sclk;
        logic sdata;
        logic strobe;
        logic ps;
        logic pol;
        logic refused;
        logic [31:0] rdata;
    } plp_host_state_t;

    localparam logic [6:0] T_LAST = T_MIN_CYC - 7'h01;
    localparam plp_host_state_t HOST_RESET = '{state: H_IDLE, pol: 1'b1, default: '0};

    plp_host_state_t r;
    plp_host_state_t n;
    logic [REF_W-1:0] ref_ratio;
    logic [MAIN_W-1:0] main_ratio;
    logic [SWAL_W-1:0] swal_ratio;
    logic idle;

    assign ref_ratio = cmd_wdata[REF_W-1:0];
    assign swal_ratio = cmd_wdata[SWAL_W-1:0];
    assign main_ratio = cmd_wdata[SWAL_W+MAIN_W-1:SWAL_W];

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = r;
        idle = (r.state == H_IDLE);
        n.sy = {r.sy[1:0], link.lock_indicator};
        n.st = plp_settle(r.sy, r.st);
        n.rdata = '0;
        n.cnt = r.cnt + 7'h01;
        case (r.state)
            H_IDLE: begin
                n.cnt = '0;
            end
            H_SETUP: begin
                if (r.cnt >= T_LAST) begin
                    n.cnt = '0;
                    n.sclk = 1'b1;
                    n.state = H_HIGH;
                end
            end
            H_HIGH: begin
                if (r.cnt >= T_LAST) begin
                    n.cnt = '0;
                    n.sclk = 1'b0;
                    if (r.bitn == '0) begin
                        n.strobe = 1'b1;
                        n.state = H_STROBE;
                    end else begin
                        n.bitn = r.bitn - 5'h01;
                        n.sdata = r.word[r.bitn - 5'h01];
                        n.state = H_SETUP;
                    end
                end
            end
            H_STROBE: begin
                if (r.cnt >= T_LAST) begin
                    n.cnt = '0;
                    n.strobe = 1'b0;
                    n.state = H_TAIL;
                end
            end
            H_TAIL: begin
                if (r.cnt >= T_LAST) begin
                    n.state = H_IDLE;
                end
            end
            default: begin
                n.state = H_IDLE;
            end
        endcase
        if (cmd_read) begin
            case (cmd_addr)
                ADDR_CTRL: n.rdata = {30'h0, r.pol, r.ps};
                ADDR_STATUS: n.rdata = {29'h0, r.refused, r.st, ~idle};
                default: n.rdata = '0;
            endcase
            if (cmd_addr == ADDR_STATUS) begin
                n.refused = 1'b0;
            end
        end
        if (cmd_write) begin
            case (cmd_addr)
                ADDR_REF: begin
                    if (!idle || ref_ratio < REF_MIN) begin
                        n.refused = 1'b1;
                    end else begin
                        n.word = {3'h0, ref_ratio, 1'b0, 1'b1};
                        n.bitn = REF_WORD_LEN - 5'h01;
                        n.sdata = ref_ratio[REF_W-1];
                        n.cnt = '0;
                        n.state = H_SETUP;
                    end
                end
                ADDR_MAIN: begin
                    if (!idle || main_ratio < MAIN_MIN) begin
                        n.refused = 1'b1;
                    end else begin
                        n.word = {main_ratio, swal_ratio, 1'b0};
                        n.bitn = MAIN_WORD_LEN - 5'h01;
                        n.sdata = main_ratio[MAIN_W-1];
                        n.cnt = '0;
                        n.state = H_SETUP;
                    end
                end
                ADDR_CTRL: begin
                    n.ps = cmd_wdata[CT_PS];
                    n.pol = cmd_wdata[CT_POL];
                end
                default: begin
                    n.refused = r.refused;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // reset holds stand-by so power-up starts with the device idle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r <= HOST_RESET;
        end else begin
            r <= n;
        end
    end

    assign link.sclk = r.sclk;
    assign link.sdata = r.sdata;
    assign link.load_strobe = r.strobe;
    assign link.power_save_input = r.ps;
    assign link.phase_polarity_input = r.pol;
    assign cmd_rdata = r.rdata;
endmodule : plp_host

// >>> sim/plp_assertions.sv
// Purpose: checker on the programming link between host and device
// Assumes: one clock domain, synchronous reset
// Notes: a shadow of the shifted bits judges each word at its strobe
`timescale 1ns/1ps
module plp_assertions (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // link wires
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe,
    input wire logic power_save_input,
    input wire logic phase_polarity_input,
    input wire logic lock_indicator
);
    logic [18:0] shadow;
    logic [4:0] bits;
    logic [6:0] held;
    logic [6:0] still;
    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    // held and still saturate so long idle spells cannot wrap
    always_ff @(posedge clock) begin
        if ($rose(sclk)) begin
            shadow <= {shadow[17:0], sdata};
        end
        bits <= (sys_rst || load_strobe) ? 5'h00 : bits + 5'($rose(sclk));
        held <= !load_strobe ? 7'h00 : held + 7'(held != 7'h7f);
        still <= (sys_rst || $changed(sdata)) ? 7'h00 : still + 7'(still != 7'h7f);
    end
    ////////////////////////////////////////////////////////////
    sequence word_done;
        $rose(load_strobe);
    endsequence
    sequence ref_done;
        word_done ##0 bits == 5'h10;
    endsequence
    sequence main_done;
        word_done ##0 bits == 5'h13;
    endsequence
    reset_pins_a: assert property (
        disable iff (1'b0) sys_rst |=> !power_save_input && phase_polarity_input)
        else $error("link pins not in stand-by after reset");
    standby_lock_a: assert property (!power_save_input [*8] |-> lock_indicator)
        else $error("lock low in stand-by");
    edge_then_strobe_a: assert property (word_done |-> !sclk && $past(sclk))
        else $error("strobe not right after last clock rise");
    strobe_quiet_a: assert property (load_strobe |-> !sclk)
        else $error("serial clock high during strobe");
    strobe_width_a: assert property ($fell(load_strobe) |-> held >= 7'h32)
        else $error("strobe pulse too short");
    setup_time_a: assert property ($rose(sclk) |-> still >= 7'h31)
        else $error("data setup too short");
    hold_time_a: assert property ($changed(sdata) |-> !sclk)
        else $error("data changed while clock high");
    word_length_a: assert property (word_done |-> bits == 5'h10 || bits == 5'h13)
        else $error("word length wrong");
    ref_word_a: assert property (
        ref_done |-> shadow[0] && !shadow[1] && shadow[15:2] >= 14'h0008)
        else $error("reference word malformed");
    main_word_a: assert property (main_done |-> !shadow[0] && shadow[18:8] >= 11'h010)
        else $error("main word malformed");
endmodule : plp_assertions

// >>> sim/tb_pll_serial_divider_control.sv
// Purpose: host and device joined over the link, driven through the command port
// Assumes: vco_in rises every 8 clocks
// Notes: scenarios share state and run in a fixed order
`timescale 1ns/1ps
module tb_pll_serial_divider_control;
    import plp_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic vco_in = 1'b0;
    logic [2:0] vco_cnt = 3'h0;
    logic [3:0] cmd_addr = 4'h0;
    logic [31:0] cmd_wdata = 32'h0;
    logic cmd_write = 1'b0;
    logic cmd_read = 1'b0;
    logic [31:0] cmd_rdata;
    logic [31:0] st;
    logic pump_out, pump_oe_n, switch_out, switch_oe_n;
    logic divided_reference, divided_vco, standby;
    int fails = 0;
    int checked = 0;
    int n;
    // pins as the loop filter sees them
    wire pump_pin = pump_oe_n ? 1'bz : pump_out;
    wire switch_pin = switch_oe_n ? 1'bz : switch_out;
    plp_link_if plp_link_if_inst ();
    plp_host plp_host_inst (.clock(clock), .sys_rst(sys_rst), .link(plp_link_if_inst), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_rdata(cmd_rdata));
    plp_device plp_device_inst (.clock(clock), .sys_rst(sys_rst), .link(plp_link_if_inst), .vco_in(vco_in),
        .pump_out(pump_out), .pump_oe_n(pump_oe_n), .switch_out(switch_out), .switch_oe_n(switch_oe_n),
        .divided_reference(divided_reference), .divided_vco(divided_vco), .standby(standby));
    plp_assertions plp_assertions_inst (.clock(clock), .sys_rst(sys_rst), .sclk(plp_link_if_inst.sclk),
        .sdata(plp_link_if_inst.sdata), .load_strobe(plp_link_if_inst.load_strobe),
        .power_save_input(plp_link_if_inst.power_save_input),
        .phase_polarity_input(plp_link_if_inst.phase_polarity_input),
        .lock_indicator(plp_link_if_inst.lock_indicator));
    always #10 clock = ~clock;
    always @(posedge clock) begin
        vco_cnt <= vco_cnt + 3'h1;
        vco_in <= vco_cnt[2];
    end
    ////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_write <= 1'b1;
        @(posedge clock);
        cmd_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        cmd_addr <= a;
        cmd_read <= 1'b1;
        @(posedge clock);
        cmd_read <= 1'b0;
        #1;
        st = cmd_rdata;
    endtask : rd
    task automatic wait_idle;
        for (int i = 0; i < 4000; i++) begin
            rd(ADDR_STATUS);
            if (st[ST_BUSY] === 1'b0) return;
        end
        fails++;
        finish_test();
    endtask : wait_idle
    // cycles between two pulses of the chosen divider
    task automatic period(input bit vco);
        int hits;
        hits = 0;
        n = 0;
        for (int i = 0; i < 40000 && hits < 2; i++) begin
            @(posedge clock);
            #1;
            if (hits == 1) n++;
            if ((vco ? divided_vco : divided_reference) === 1'b1) hits++;
        end
        if (hits < 2) begin
            fails++;
            finish_test();
        end
    endtask : period
    // vco is far slower, so the pump should be pushing up
    task automatic pump_check(input logic exp);
        for (int i = 0; i < 100 && divided_reference !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        check(divided_reference, 1'b1);
        repeat (5) @(posedge clock);
        #1;
        check(pump_pin, exp);
    endtask : pump_check
    ////////////////////////////////////////////////////////////
    task automatic s_reset;
        // the host sees the lock pin only after its own settling stages
        repeat (4) @(posedge clock);
        rd(ADDR_STATUS);
        check(st, 32'h2);
        rd(ADDR_CTRL);
        check(st, 32'h2);
        check({standby, pump_pin, switch_pin}, {1'b1, 1'bz, 1'bz});
    endtask : s_reset
    task automatic s_refuse;
        wr(ADDR_REF, 32'h7);
        rd(ADDR_STATUS);
        check(st & 32'h4, 32'h4);
        rd(ADDR_STATUS);
        check(st & 32'h4, 32'h0);
        wr(ADDR_MAIN, 32'h780);
        rd(ADDR_STATUS);
        check(st & 32'h4, 32'h4);
        rd(ADDR_STATUS);
    endtask : s_refuse
    task automatic s_program;
        wr(ADDR_REF, 32'ha);
        wait_idle();
        wr(ADDR_MAIN, 32'h805);
        wait_idle();
        wr(ADDR_CTRL, 32'h3);
        period(1'b0);
        check(n, 10);
        check(standby, 1'b0);
        period(1'b1);
        check(n, 8 * (128 * 16 + 5));
    endtask : s_program
    task automatic s_pump;
        pump_check(1'b1);
        check(plp_link_if_inst.lock_indicator, 1'b0);
        wr(ADDR_CTRL, 32'h1);
        pump_check(1'b0);
        wr(ADDR_CTRL, 32'h3);
    endtask : s_pump
    task automatic s_switch;
        wr(ADDR_REF, 32'h8);
        for (int i = 0; i < 3000 && plp_link_if_inst.load_strobe !== 1'b1; i++) @(posedge clock);
        check(plp_link_if_inst.load_strobe, 1'b1);
        repeat (10) @(posedge clock);
        #1;
        check({switch_oe_n, switch_pin}, {1'b0, pump_pin});
        wait_idle();
        check(switch_pin, 1'bz);
        period(1'b0);
        check(n, 8);
    endtask : s_switch
    task automatic s_standby;
        wr(ADDR_CTRL, 32'h2);
        repeat (10) @(posedge clock);
        #1;
        check({standby, pump_pin, plp_link_if_inst.lock_indicator}, {1'b1, 1'bz, 1'b1});
        n = 0;
        repeat (50) begin
            @(posedge clock);
            #1;
            if (divided_reference !== 1'b0) n++;
        end
        check(n, 0);
        wr(ADDR_CTRL, 32'h3);
        for (int i = 0; i < 20 && standby !== 1'b0; i++) begin
            @(posedge clock);
            #1;
        end
        check(standby, 1'b0);
        // a restarted divider gives its first pulse a full ratio after wake
        n = 0;
        for (int i = 0; i < 20 && divided_reference !== 1'b1; i++) begin
            @(posedge clock);
            #1;
            n++;
        end
        check(n, 8);
        period(1'b0);
        check(n, 8);
    endtask : s_standby
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        s_reset();
        s_refuse();
        s_program();
        s_pump();
        s_switch();
        s_standby();
        finish_test();
    end
endmodule : tb_pll_serial_divider_control
